// File: adc_wrap_and_trigger_select.sv
// Converter sequencer control: wrap channel, trigger source and AXI4-Lite registers.
//
// Overview of operation
// - Writing wrap or trigger-source register aborts the running sequence, starts none.
// - Wrap field bits 3:0 names last scan channel; code zero reserved.
// - In multi-channel mode the scan continues at channel zero after the wrap channel.
// - Source-select bit 7 picks channel field source or dedicated trigger input.
// - Trigger channel field bits 3:0 selects analog channel 0 to 15.
// - Without a dedicated input, source-select only stores; channel stays the source.
// - Both control registers readable and writable at any time.
// - Trigger acts only when enabled; selected analog channel gets its input buffer on.
// - Level/edge and polarity bits give falling, rising, low or high sensitivity.
`timescale 1ns/10ps
module adc_wrap_and_trigger_select
  import adc_wrap_pkg::*;
#(
  parameter int NUM_CH = 16,
  parameter bit HAS_DEDICATED_TRIGGER = 1'b1
) (
  input wire logic mclk, // Module clock, 25 MHz.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic [adc_wrap_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [adc_wrap_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [NUM_CH-1:0] analog_pin_level, // Digital view of the analog pins.
  input wire logic dedicated_trigger_input, // Dedicated trigger pin.
  input wire logic conversion_done, // Converter finished the current channel.
  output logic [NUM_CH-1:0] input_buffer_enable, // Digital input buffer enables.
  output logic [3:0] conv_channel, // Channel being converted.
  output logic conv_active, // Sequence in progress.
  output logic seq_abort // One-cycle pulse when a sequence is aborted.
);
  import adc_wrap_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  // Word index of a byte address; used by both read and write paths.
  function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = a[7:2];
  endfunction

  // ****************************************
  // Bus and register state
  // ****************************************
  logic aw_got_ff, nxt_aw_got;
  logic w_got_ff, nxt_w_got;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic wstrb0_ff, nxt_wstrb0;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [7:0] wrap_ff, nxt_wrap;
  logic [7:0] tsrc_ff, nxt_tsrc;
  logic [7:0] tcfg_ff, nxt_tcfg;
  logic [7:0] seqc_ff, nxt_seqc;
  logic [7:0] dien_hi_ff, nxt_dien_hi;
  logic [7:0] dien_lo_ff, nxt_dien_lo;
  logic do_write;
  logic [5:0] widx;
  logic abort_req;
  logic start_req;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic arready_ff, nxt_arready;

  // Write executes once both address and data are held and no response is pending.
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  assign widx = word_index(awaddr_ff);

  // Accept address and data independently, then execute the write.
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_wrap = wrap_ff;
    nxt_tsrc = tsrc_ff;
    nxt_tcfg = tcfg_ff;
    nxt_seqc = seqc_ff;
    nxt_dien_hi = dien_hi_ff;
    nxt_dien_lo = dien_lo_ff;
    abort_req = 1'b0;
    start_req = 1'b0;
    if (s_axi_awvalid && !aw_got_ff) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_ff) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      // Registers are written in any state of the converter
      unique case (widx)
        IDX_WRAP_CHANNEL_CONTROL: begin
          if (wstrb0_ff) nxt_wrap = wdata_ff[7:0] & WRAP_MASK;
          abort_req = 1'b1;
        end
        IDX_TRIGGER_SOURCE_CONTROL: begin
          if (wstrb0_ff) nxt_tsrc = wdata_ff[7:0] & TRIG_SRC_MASK;
          abort_req = 1'b1;
        end
        IDX_TRIGGER_CONFIG: begin
          if (wstrb0_ff) nxt_tcfg = wdata_ff[7:0] & TRIG_CFG_MASK;
        end
        IDX_SEQUENCE_CONTROL: begin
          if (wstrb0_ff) begin
            nxt_seqc = wdata_ff[7:0] & SEQ_CTL_MASK;
            start_req = wdata_ff[SEQ_START_BIT];
          end
        end
        IDX_DIGITAL_INPUT_ENABLE_HIGH: begin
          if (wstrb0_ff) nxt_dien_hi = wdata_ff[7:0];
        end
        IDX_DIGITAL_INPUT_ENABLE_LOW: begin
          if (wstrb0_ff) nxt_dien_lo = wdata_ff[7:0];
        end
        IDX_PIN_LEVEL_HIGH, IDX_PIN_LEVEL_LOW, IDX_SEQUENCE_STATUS: begin
          nxt_bresp = RESP_OKAY;
        end
        default: begin
          nxt_bresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_awready = !nxt_aw_got;
    nxt_wready = !nxt_w_got;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_got_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= DATA_ZERO;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      wrap_ff <= WRAP_RESET;
      tsrc_ff <= TRIG_SRC_RESET;
      tcfg_ff <= TRIG_CFG_RESET;
      seqc_ff <= SEQ_CTL_RESET;
      dien_hi_ff <= 8'h00;
      dien_lo_ff <= 8'h00;
    end else begin
      aw_got_ff <= nxt_aw_got;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      wrap_ff <= nxt_wrap;
      tsrc_ff <= nxt_tsrc;
      tcfg_ff <= nxt_tcfg;
      seqc_ff <= nxt_seqc;
      dien_hi_ff <= nxt_dien_hi;
      dien_lo_ff <= nxt_dien_lo;
    end
  end

  // Ready is high while the channel's holding slot is empty, registered so the pin is a flop.
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ****************************************
  // Trigger source selection
  // ****************************************
  logic [3:0] trig_ch;
  logic use_dedicated;
  logic trig_level;
  logic trig_fire;
  logic trig_en;
  trig_mode_t trig_mode;

  assign trig_ch = tsrc_ff[TRIG_CH_LSB +: 4];
  // Without the dedicated pin the select bit is stored but inert.
  assign use_dedicated = tsrc_ff[TRIG_SEL_BIT] && HAS_DEDICATED_TRIGGER;
  assign trig_level = use_dedicated ? dedicated_trigger_input : analog_pin_level[trig_ch];
  assign trig_en = tcfg_ff[TRIG_EN_BIT];
  // One driver for the whole struct; fields in declaration order.
  assign trig_mode = {tcfg_ff[TRIG_LE_BIT], tcfg_ff[TRIG_POL_BIT]};

  trigger_detect u_detect (
    .mclk(mclk),
    .nrst(nrst),
    .trig_in(trig_level),
    .mode(trig_mode),
    .fire(trig_fire)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_t state_ff, nxt_state;
  logic [3:0] chan_ff, nxt_chan;
  logic abort_ff, nxt_abort;
  logic [NUM_CH-1:0] ibuf_ff, nxt_ibuf;
  logic active_ff, nxt_active;

  // An abort wins over any start in the same cycle so a control write never launches a scan.
  always_comb begin
    nxt_state = state_ff;
    nxt_chan = chan_ff;
    nxt_abort = 1'b0;
    nxt_ibuf = {dien_hi_ff, dien_lo_ff};
    if (trig_en && !use_dedicated) begin
      nxt_ibuf[trig_ch] = 1'b1;
    end
    unique case (state_ff)
      SEQ_IDLE: begin
        if (!abort_req && (start_req || (trig_en && trig_fire))) begin
          nxt_state = SEQ_RUN;
          nxt_chan = CHAN_ZERO;
        end
      end
      SEQ_RUN: begin
        if (abort_req) begin
          nxt_state = SEQ_IDLE;
          nxt_abort = 1'b1;
        end else if (conversion_done) begin
          if (seqc_ff[SEQ_MULTI_CHANNEL_MODE_BIT] && chan_ff == wrap_ff[WRAP_LSB +: 4]) begin
            nxt_chan = CHAN_ZERO;
          end else if (seqc_ff[SEQ_MULTI_CHANNEL_MODE_BIT]) begin
            nxt_chan = chan_ff + 4'h1;
          end
        end
      end
    endcase
    nxt_active = (nxt_state == SEQ_RUN);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_ff <= SEQ_IDLE;
      active_ff <= 1'b0;
      chan_ff <= CHAN_ZERO;
      abort_ff <= 1'b0;
      ibuf_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      active_ff <= nxt_active;
      chan_ff <= nxt_chan;
      abort_ff <= nxt_abort;
      ibuf_ff <= nxt_ibuf;
    end
  end

  assign conv_active = active_ff;
  assign conv_channel = chan_ff;
  assign seq_abort = abort_ff;
  assign input_buffer_enable = ibuf_ff;

  // ****************************************
  // Read path
  // ****************************************
  // One read at a time; address is taken only when no data is pending.
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready) nxt_rvalid = 1'b0;
    if (s_axi_arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = DATA_ZERO;
      unique case (word_index(s_axi_araddr))
        IDX_WRAP_CHANNEL_CONTROL: nxt_rdata[7:0] = wrap_ff;
        IDX_TRIGGER_SOURCE_CONTROL: nxt_rdata[7:0] = tsrc_ff;
        IDX_TRIGGER_CONFIG: nxt_rdata[7:0] = tcfg_ff;
        IDX_SEQUENCE_CONTROL: nxt_rdata[7:0] = seqc_ff;
        IDX_SEQUENCE_STATUS: nxt_rdata[7:0] = {3'b000, conv_active, chan_ff};
        IDX_DIGITAL_INPUT_ENABLE_HIGH: nxt_rdata[7:0] = dien_hi_ff;
        IDX_DIGITAL_INPUT_ENABLE_LOW: nxt_rdata[7:0] = dien_lo_ff;
        IDX_PIN_LEVEL_HIGH: nxt_rdata[7:0] = analog_pin_level[15:8] & dien_hi_ff;
        IDX_PIN_LEVEL_LOW: nxt_rdata[7:0] = analog_pin_level[7:0] & dien_lo_ff;
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
      rdata_ff <= DATA_ZERO;
      rresp_ff <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= nxt_arready;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ****************************************
  // Checks
  // ****************************************
  property p_abort_stops;
    @(posedge mclk) disable iff (!nrst)
      (abort_req && conv_active) |=> (!conv_active && seq_abort);
  endproperty
  a_abort_stops: assert property (p_abort_stops) else $error("abort did not stop");

  property p_no_start_on_ctl;
    @(posedge mclk) disable iff (!nrst)
      (abort_req && !conv_active) |=> !conv_active;
  endproperty
  a_no_start_on_ctl: assert property (p_no_start_on_ctl) else $error("control write started");

  property p_wrap_back;
    @(posedge mclk) disable iff (!nrst)
      (conv_active && !abort_req && conversion_done && seqc_ff[SEQ_MULTI_CHANNEL_MODE_BIT]
       && chan_ff == wrap_ff[3:0]) |=> (conv_channel == CHAN_ZERO);
  endproperty
  a_wrap_back: assert property (p_wrap_back) else $error("scan did not wrap");

  property p_wrap_unused_zero;
    @(posedge mclk) disable iff (!nrst)
      (wrap_ff[7:4] == 4'h0) && (tsrc_ff[6:4] == 3'b000);
  endproperty
  a_wrap_unused_zero: assert property (p_wrap_unused_zero) else $error("unused bits set");

  property p_wrap_store;
    @(posedge mclk) disable iff (!nrst)
      (do_write && widx == IDX_WRAP_CHANNEL_CONTROL && wstrb0_ff)
        |=> (wrap_ff[3:0] == $past(wdata_ff[3:0]));
  endproperty
  a_wrap_store: assert property (p_wrap_store) else $error("wrap not stored");

  property p_dedicated_src;
    @(posedge mclk) disable iff (!nrst)
      (tsrc_ff[7] && HAS_DEDICATED_TRIGGER) |-> (trig_level == dedicated_trigger_input);
  endproperty
  a_dedicated_src: assert property (p_dedicated_src) else $error("wrong trigger source");

  property p_channel_src;
    @(posedge mclk) disable iff (!nrst)
      !use_dedicated |-> (trig_level == analog_pin_level[tsrc_ff[3:0]]);
  endproperty
  a_channel_src: assert property (p_channel_src) else $error("wrong channel source");

  property p_trig_needs_enable;
    @(posedge mclk) disable iff (!nrst)
      (!conv_active && !trig_en && !start_req) |=> !conv_active;
  endproperty
  a_trig_needs_enable: assert property (p_trig_needs_enable) else $error("disabled trigger fired");

  property p_buffer_on;
    @(posedge mclk) disable iff (!nrst)
      (trig_en && !use_dedicated) |=> input_buffer_enable[$past(trig_ch)];
  endproperty
  a_buffer_on: assert property (p_buffer_on) else $error("buffer not enabled");
endmodule

// File: adc_wrap_pkg.sv
// Package with register map, field layout and types for the converter wrap and trigger block.
package adc_wrap_pkg;

  // ****************************************
  // Register word indices
  // ****************************************
  // Index offsets as printed, byte address is four times the index.
  localparam logic [5:0] IDX_WRAP_CHANNEL_CONTROL = 6'h00;
  localparam logic [5:0] IDX_TRIGGER_SOURCE_CONTROL = 6'h01;
  localparam logic [5:0] IDX_TRIGGER_CONFIG = 6'h02;
  localparam logic [5:0] IDX_SEQUENCE_CONTROL = 6'h05;
  localparam logic [5:0] IDX_SEQUENCE_STATUS = 6'h06;
  localparam logic [5:0] IDX_DIGITAL_INPUT_ENABLE_HIGH = 6'h0c;
  localparam logic [5:0] IDX_DIGITAL_INPUT_ENABLE_LOW = 6'h0d;
  localparam logic [5:0] IDX_PIN_LEVEL_HIGH = 6'h0e;
  localparam logic [5:0] IDX_PIN_LEVEL_LOW = 6'h0f;
  localparam int ADDR_W = 8;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int WRAP_LSB = 0;
  localparam int TRIG_CH_LSB = 0;
  localparam int TRIG_SEL_BIT = 7;
  localparam int TRIG_LE_BIT = 4;
  localparam int TRIG_POL_BIT = 3;
  localparam int TRIG_EN_BIT = 2;
  localparam int SEQ_MULTI_CHANNEL_MODE_BIT = 4;
  localparam int SEQ_START_BIT = 0;
  localparam logic [7:0] WRAP_MASK = 8'h0f;
  localparam logic [7:0] TRIG_SRC_MASK = 8'h8f;
  localparam logic [7:0] TRIG_CFG_MASK = 8'h1c;
  localparam logic [7:0] SEQ_CTL_MASK = 8'h10;
  localparam logic [7:0] WRAP_RESET = 8'h0f;
  localparam logic [7:0] TRIG_SRC_RESET = 8'h00;
  localparam logic [7:0] TRIG_CFG_RESET = 8'h00;
  localparam logic [7:0] SEQ_CTL_RESET = 8'h00;
  localparam logic [3:0] CHAN_ZERO = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // ****************************************
  // Types
  // ****************************************
  // Trigger configuration carried together to the detector.
  typedef struct packed {
    logic level_edge_select;
    logic trigger_polarity_bit;
  } trig_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RUN
  } seq_state_t;

endpackage

// File: tb_adc_wrap_and_trigger_select.sv
// Self-checking testbench for the converter wrap and trigger-source block.
`timescale 1ns/10ps
module tb_adc_wrap_and_trigger_select;
  import adc_wrap_pkg::*;
  // ****************************************
  // Signals and instance
  // ****************************************
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] analog_pin_level = 16'h0000;
  logic dedicated_trigger_input = 1'b0;
  logic conversion_done = 1'b0;
  logic [15:0] input_buffer_enable;
  logic [3:0] conv_channel;
  logic conv_active, seq_abort;
  int error_cnt = 0;
  int tests_run = 0;
  int abort_cnt = 0;
  logic nopin_active;
  logic [15:0] nopin_ibuf;

  adc_wrap_and_trigger_select #(.NUM_CH(16), .HAS_DEDICATED_TRIGGER(1'b1))
      adc_wrap_and_trigger_select_inst (
    .mclk(mclk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .analog_pin_level(analog_pin_level), .dedicated_trigger_input(dedicated_trigger_input),
    .conversion_done(conversion_done), .input_buffer_enable(input_buffer_enable),
    .conv_channel(conv_channel), .conv_active(conv_active), .seq_abort(seq_abort));

  // Twin without the dedicated pin, fed the same bus traffic; its select bit must be inert.
  adc_wrap_and_trigger_select #(.NUM_CH(16), .HAS_DEDICATED_TRIGGER(1'b0))
      adc_wrap_and_trigger_select_nopin_inst (
    .mclk(mclk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
    .analog_pin_level(analog_pin_level), .dedicated_trigger_input(dedicated_trigger_input),
    .conversion_done(conversion_done), .input_buffer_enable(nopin_ibuf),
    .conv_channel(), .conv_active(nopin_active), .seq_abort());

  // ****************************************
  // Clock, abort monitor and watchdog
  // ****************************************
  // Half period of 20 ns gives the 25 MHz module clock.
  initial begin
    forever #20 mclk = ~mclk;
  end

  // Sampled on the falling edge, where the registered pulse is settled.
  always @(negedge mclk) begin
    if (seq_abort === 1'b1) abort_cnt++;
  end

  // The whole run needs well under 2000 cycles, so this only trips on a hang.
  initial begin
    repeat (8000) @(posedge mclk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Entered just after a rising edge; handshakes are judged on the settled falling edge.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge mclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge mclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      // Raised one edge after the request, so calls in a row never assign it twice at once.
      s_axi_bready <= !b_hs;
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge mclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      s_axi_rready <= !r_hs;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk(d, exp, "read data");
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Reset values, unused bits and an unmapped place.
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(8'h00, 32'h0000_000f);
    rd_chk(8'h04, 32'h0000_0000);
    wr(8'h00, 32'hffff_ffff);
    rd_chk(8'h00, 32'h0000_000f);
    wr(8'h04, 32'hffff_ffff);
    rd_chk(8'h04, 32'h0000_008f);
    wr(8'h04, 32'h0000_0070);
    rd_chk(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000);
    axi_read(8'hfc, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    axi_write(8'hfc, 32'h0000_00a5, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    $display("test regs done");
  endtask

  // Multi-channel scan to the wrap channel and back to zero, then an abort.
  task automatic t_wrap(input logic [3:0] w, input logic [7:0] abort_addr);
    int a0;
    wr(8'h00, {28'h0, w});
    wr(8'h14, 32'h0000_0011);
    cyc(1);
    chk({31'h0, conv_active}, 32'h1, "scan running");
    chk({28'h0, conv_channel}, 32'h0, "first channel");
    for (int i = 1; i <= w + 2; i++) begin
      conversion_done <= 1'b1;
      cyc(1);
      conversion_done <= 1'b0;
      cyc(2);
      chk({28'h0, conv_channel}, i % (w + 1), "scan channel");
    end
    a0 = abort_cnt;
    wr(abort_addr, 32'h0000_0000);
    cyc(3);
    chk({31'h0, conv_active}, 32'h0, "aborted");
    chk(abort_cnt - a0, 32'h1, "one abort pulse");
    cyc(4);
    chk({31'h0, conv_active}, 32'h0, "no restart");
    $display("test wrap done");
  endtask

  // Analog channel as trigger source, with its input buffer switched on.
  task automatic t_trig_chan();
    wr(8'h34, 32'h0000_0000);
    wr(8'h04, 32'h0000_0005);
    wr(8'h08, 32'h0000_000c);
    cyc(2);
    chk({16'h0, input_buffer_enable}, 32'h0000_0020, "buffer of trigger ch");
    analog_pin_level <= 16'h0010;
    cyc(4);
    chk({31'h0, conv_active}, 32'h0, "other channel ignored");
    analog_pin_level <= 16'h0030;
    cyc(4);
    chk({31'h0, conv_active}, 32'h1, "channel trigger fired");
    rd_chk(8'h18, 32'h0000_0010);
    wr(8'h04, 32'h0000_0085);
    analog_pin_level <= 16'h0000;
    cyc(2);
    analog_pin_level <= 16'h0020;
    cyc(4);
    chk({31'h0, conv_active}, 32'h0, "channel ignored when dedicated");
    chk({16'h0, input_buffer_enable}, 32'h0, "no buffer for dedicated");
    chk({31'h0, nopin_active}, 32'h1, "select bit inert without pin");
    chk({16'h0, nopin_ibuf}, 32'h0000_0020, "buffer kept without pin");
    analog_pin_level <= 16'h0000;
    $display("test trigger channel done");
  endtask

  // Dedicated input in each of the four sensitivities, plus trigger disabled.
  task automatic t_trig_modes();
    logic pol;
    for (int m = 0; m < 4; m++) begin
      pol = m[0];
      dedicated_trigger_input <= ~pol;
      wr(8'h08, {24'h0, 3'b000, m[1], m[0], 3'b000});
      wr(8'h04, 32'h0000_0080);
      dedicated_trigger_input <= pol;
      cyc(4);
      chk({31'h0, conv_active}, 32'h0, "trigger disabled");
      dedicated_trigger_input <= ~pol;
      wr(8'h08, {24'h0, 3'b000, m[1], m[0], 3'b100});
      cyc(4);
      chk({31'h0, conv_active}, 32'h0, "idle level no start");
      dedicated_trigger_input <= pol;
      cyc(4);
      chk({31'h0, conv_active}, 32'h1, "sensitivity start");
      // Abort with the pin held active: a level restarts the scan, an edge does not.
      wr(8'h04, 32'h0000_0080);
      cyc(4);
      chk({31'h0, conv_active}, {31'h0, m[1]}, "level restarts, edge does not");
      dedicated_trigger_input <= ~pol;
      cyc(2);
    end
    wr(8'h04, 32'h0000_0000);
    $display("test trigger modes done");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_wrap(4'h3, 8'h04);
    t_wrap(4'hf, 8'h00);
    t_trig_chan();
    t_trig_modes();
    end_sim();
  end
endmodule

// File: trigger_detect.sv
// Trigger sensitivity detector: edge or level, either polarity.
`timescale 1ns/10ps
module trigger_detect
  import adc_wrap_pkg::*;
(
  input wire logic mclk, // Module clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic trig_in, // Selected trigger source level.
  input wire adc_wrap_pkg::trig_mode_t mode, // Sensitivity mode.
  output logic fire // High while the trigger condition holds.
);
  logic prev_ff;
  logic nxt_prev;

  // Keep the previous level for edge detection.
  always_comb begin
    nxt_prev = trig_in;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // Track the pin during reset so an idle-high source shows no false edge on release.
      prev_ff <= nxt_prev;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  // Decode 00 falling, 01 rising, 10 low level, 11 high level.
  always_comb begin
    unique case ({mode.level_edge_select, mode.trigger_polarity_bit})
      2'b00: fire = prev_ff & ~trig_in;
      2'b01: fire = ~prev_ff & trig_in;
      2'b10: fire = ~trig_in;
      2'b11: fire = trig_in;
    endcase
  end

  property p_rise_fire;
    @(posedge mclk) disable iff (!nrst)
      ({mode.level_edge_select, mode.trigger_polarity_bit} == 2'b01 && $rose(trig_in)) |-> fire;
  endproperty
  a_rise_fire: assert property (p_rise_fire) else $error("rising edge missed");

  property p_high_level;
    @(posedge mclk) disable iff (!nrst)
      ({mode.level_edge_select, mode.trigger_polarity_bit} == 2'b11) |-> (fire == trig_in);
  endproperty
  a_high_level: assert property (p_high_level) else $error("high level wrong");
endmodule
